/* logic/bvs_top.sv */
// What this block does
// - Control bit 5 selects regulator two target, bit 1 regulator one; reset 0.
// - Go bits 4 and 0: 0 holds output, 1 ramps to selected target; reset 0.
// - Regulator one code 0 is external; 1..19h is 0.80-2.00 V; above saturates.
// - Regulator two code 0 external; 1.0 V up by 0.1 V, 2.3 V skipped.
// - Ramp rate 0 is instant, 1..Ah is 1-10 mV/us, above behaves as 10.
// - Ramp register resets rate 1000, bits 6-4 to 010, bit 7 to 0.
// - Target registers: bits 7-5 reserved zero; field resets to variant default.
`timescale 1ns/100ps
module bvs_top #(
  parameter logic [4:0] REG_ONE_DEFAULT_A = 5'h09,
  parameter logic [4:0] REG_ONE_DEFAULT_B = 5'h09,
  parameter logic [4:0] REG_TWO_DEFAULT_A = 5'h19
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic [4:0] reg_two_second_target_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  output logic      [4:0] reg_one_active_code_o,
  output logic      [4:0] reg_two_active_code_o
);
  logic       reg_one_ramp_go;
  logic       reg_one_target_select;
  logic       reg_two_ramp_go;
  logic       reg_two_target_select;
  logic [4:0] reg_one_target_code_a;
  logic [4:0] reg_one_target_code_b;
  logic [4:0] reg_two_target_code_a;
  logic [3:0] reg_one_ramp_rate_code;
  logic [7:0] us_cnt;
  logic       us_tick;
  logic [7:0] next_rdata;

  bvs_ramp_if one_if ();
  bvs_ramp_if two_if ();

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // voltage change control: select and go bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_one_ramp_go       <= 1'b0;
      reg_one_target_select <= 1'b0;
      reg_two_ramp_go       <= 1'b0;
      reg_two_target_select <= 1'b0;
    end else if (reg_wr_i && (reg_addr_i == bvs_pkg::VOLTAGE_CHANGE_CONTROL)) begin
      reg_one_target_select <= reg_wdata_i[bvs_pkg::REG_ONE_TARGET_SELECT];
      reg_two_target_select <= reg_wdata_i[bvs_pkg::REG_TWO_TARGET_SELECT];
      reg_one_ramp_go       <= reg_wdata_i[bvs_pkg::REG_ONE_RAMP_GO];
      reg_two_ramp_go       <= reg_wdata_i[bvs_pkg::REG_TWO_RAMP_GO];
    end
  end

  // target codes, reset to the variant defaults
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_one_target_code_a <= REG_ONE_DEFAULT_A;
      reg_one_target_code_b <= REG_ONE_DEFAULT_B;
      reg_two_target_code_a <= REG_TWO_DEFAULT_A;
    end else if (reg_wr_i) begin
      if (reg_addr_i == bvs_pkg::BUCK_ONE_TARGET_A) begin
        reg_one_target_code_a <= reg_wdata_i[4:0];
      end
      if (reg_addr_i == bvs_pkg::BUCK_ONE_TARGET_B) begin
        reg_one_target_code_b <= reg_wdata_i[4:0];
      end
      if (reg_addr_i == bvs_pkg::BUCK_TWO_TARGET_A) begin
        reg_two_target_code_a <= reg_wdata_i[4:0];
      end
    end
  end

  // ramp rate code
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_one_ramp_rate_code <= bvs_pkg::RATE_RESET;
    end else if (reg_wr_i && (reg_addr_i == bvs_pkg::BUCK_ONE_RAMP_RATE)) begin
      reg_one_ramp_rate_code <= reg_wdata_i[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // reserved bits read as zero, ramp bits 6-4 as their fixed value
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      bvs_pkg::VOLTAGE_CHANGE_CONTROL: begin
        next_rdata[bvs_pkg::REG_TWO_TARGET_SELECT] = reg_two_target_select;
        next_rdata[bvs_pkg::REG_TWO_RAMP_GO]       = reg_two_ramp_go;
        next_rdata[bvs_pkg::REG_ONE_TARGET_SELECT] = reg_one_target_select;
        next_rdata[bvs_pkg::REG_ONE_RAMP_GO]       = reg_one_ramp_go;
      end
      bvs_pkg::BUCK_ONE_TARGET_A:  next_rdata = {3'h0, reg_one_target_code_a};
      bvs_pkg::BUCK_ONE_TARGET_B:  next_rdata = {3'h0, reg_one_target_code_b};
      bvs_pkg::BUCK_TWO_TARGET_A:  next_rdata = {3'h0, reg_two_target_code_a};
      bvs_pkg::BUCK_ONE_RAMP_RATE: begin
        next_rdata = {1'b0, bvs_pkg::RAMP_RSVD, reg_one_ramp_rate_code};
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // microsecond enable and ramp steppers

  // one-cycle enable every microsecond
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      us_cnt  <= 8'h00;
      us_tick <= 1'b0;
    end else if (us_cnt == 8'(bvs_pkg::CYC_PER_US - 1)) begin
      us_cnt  <= 8'h00;
      us_tick <= 1'b1;
    end else begin
      us_cnt  <= us_cnt + 8'h01;
      us_tick <= 1'b0;
    end
  end

  // selected and saturated targets toward each stepper
  assign one_if.go      = reg_one_ramp_go;
  assign one_if.target  = bvs_pkg::sat_code(reg_one_target_select ? reg_one_target_code_b
                                            : reg_one_target_code_a);
  assign one_if.rate    = bvs_pkg::sat_rate(reg_one_ramp_rate_code);
  assign one_if.us_tick = us_tick;
  assign two_if.go      = reg_two_ramp_go;
  assign two_if.target  = bvs_pkg::sat_code(reg_two_target_select ? reg_two_second_target_i
                                            : reg_two_target_code_a);
  assign two_if.rate    = bvs_pkg::REG_TWO_RATE;
  assign two_if.us_tick = us_tick;

  bvs_ramp_stepper #(
    .STEP_MV   (bvs_pkg::REG_ONE_STEP_MV),
    .SKIP_CODE (bvs_pkg::NO_SKIP),
    .INIT_CODE (REG_ONE_DEFAULT_A)
  ) u_one (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rp        (one_if.stepper)
  );

  bvs_ramp_stepper #(
    .STEP_MV   (bvs_pkg::REG_TWO_STEP_MV),
    .SKIP_CODE (bvs_pkg::REG_TWO_SKIP),
    .INIT_CODE (REG_TWO_DEFAULT_A)
  ) u_two (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rp        (two_if.stepper)
  );

  assign reg_one_active_code_o = one_if.code;
  assign reg_two_active_code_o = two_if.code;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_sel_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == bvs_pkg::VOLTAGE_CHANGE_CONTROL)
      |=> (reg_one_target_select == $past(reg_wdata_i[1]))
          && (reg_two_target_select == $past(reg_wdata_i[5])))
    else $error("target select not taken from control write");

  a_hold_no_go: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !reg_one_ramp_go |=> $stable(reg_one_active_code_o))
    else $error("regulator one code moved without go");

  a_instant_jump: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_one_ramp_go && reg_one_ramp_rate_code == 4'h0 && !reg_wr_i)
      |=> reg_one_active_code_o == $past(one_if.target))
    else $error("instant rate did not jump to target");

  a_one_code_sat: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_one_active_code_o <= 5'h19)
    else $error("regulator one code above top entry");

  a_two_code_sat: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_two_active_code_o <= 5'h19)
    else $error("regulator two code above top entry");

  a_rate_reset_val: assert property (
    @(posedge ref_clk_i)
    !rst_n_i |=> reg_one_ramp_rate_code == 4'h8)
    else $error("ramp rate not reset to eight");

  a_ramp_rsvd_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == bvs_pkg::BUCK_ONE_RAMP_RATE)
      |=> reg_rvalid_o && reg_rdata_o[7:4] == 4'h2)
    else $error("ramp register upper bits wrong");

  a_target_rsvd_read: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && (reg_addr_i == bvs_pkg::BUCK_ONE_TARGET_A
                  || reg_addr_i == bvs_pkg::BUCK_TWO_TARGET_A))
      |=> reg_rdata_o[7:5] == 3'h0)
    else $error("target register reserved bits not zero");

  a_ramp_single_step: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_one_ramp_go && reg_one_ramp_rate_code != 4'h0 && one_if.target != 5'h00
     && reg_one_active_code_o != 5'h00 && !reg_wr_i)
      |=> (reg_one_active_code_o == $past(reg_one_active_code_o))
          || (reg_one_active_code_o == $past(reg_one_active_code_o) + 5'h01)
          || (reg_one_active_code_o == $past(reg_one_active_code_o) - 5'h01))
    else $error("ramp moved more than one code per step");
endmodule

/* logic/bvs_pkg.sv */
package bvs_pkg;
  // register offsets
  localparam logic [7:0] VOLTAGE_CHANGE_CONTROL = 8'h20;
  localparam logic [7:0] BUCK_ONE_TARGET_A      = 8'h23;
  localparam logic [7:0] BUCK_ONE_TARGET_B      = 8'h24;
  localparam logic [7:0] BUCK_ONE_RAMP_RATE     = 8'h25;
  localparam logic [7:0] BUCK_TWO_TARGET_A      = 8'h29;

  // control register field positions
  localparam int REG_TWO_TARGET_SELECT = 5;
  localparam int REG_TWO_RAMP_GO       = 4;
  localparam int REG_ONE_TARGET_SELECT = 1;
  localparam int REG_ONE_RAMP_GO       = 0;

  // reset values and code limits
  localparam logic [3:0] RATE_RESET     = 4'h8;
  localparam logic [2:0] RAMP_RSVD      = 3'h2;
  localparam logic [3:0] RATE_MAX       = 4'ha;
  localparam logic [3:0] RATE_INSTANT   = 4'h0;
  localparam logic [4:0] CODE_EXT       = 5'h00;
  localparam logic [4:0] CODE_MAX       = 5'h19;
  localparam logic [3:0] REG_TWO_RATE   = 4'h8;

  // voltage steps and the missing point of the second regulator
  localparam int         REG_ONE_STEP_MV = 50;
  localparam int         REG_TWO_STEP_MV = 100;
  localparam logic [4:0] REG_TWO_SKIP    = 5'h0e;
  localparam logic [4:0] NO_SKIP         = 5'h00;

  // microsecond tick derived from the clock rate
  localparam int CLK_MHZ     = 250;
  localparam int TICK_US     = 1;
  localparam int CYC_PER_US  = TICK_US * CLK_MHZ;

  // codes above the table top behave as the top entry
  function automatic logic [4:0] sat_code(input logic [4:0] c);
    sat_code = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction

  // rates above ten behave as ten
  function automatic logic [3:0] sat_rate(input logic [3:0] r);
    sat_rate = (r > RATE_MAX) ? RATE_MAX : r;
  endfunction
endpackage

/* logic/bvs_ramp_if.sv */
`timescale 1ns/100ps
interface bvs_ramp_if;
  logic       go;
  logic [4:0] target;
  logic [3:0] rate;
  logic       us_tick;
  logic [4:0] code;

  modport ctrl (output go, output target, output rate, output us_tick, input code);
  modport stepper (input go, input target, input rate, input us_tick, output code);
endinterface

/* logic/bvs_ramp_stepper.sv */
`timescale 1ns/100ps
module bvs_ramp_stepper #(
  parameter int         STEP_MV   = 50,
  parameter logic [4:0] SKIP_CODE = 5'h00,
  parameter logic [4:0] INIT_CODE = 5'h01
) (
  input  wire logic    ref_clk_i,
  input  wire logic    rst_n_i,
  bvs_ramp_if.stepper  rp
);
  logic [7:0] acc;
  logic [7:0] cost;
  logic [7:0] sum;
  logic       up;
  logic       instant;

  // the skipped point doubles the voltage of that one step
  always_comb begin
    up      = rp.target > rp.code;
    instant = (rp.rate == bvs_pkg::RATE_INSTANT) || (rp.target == bvs_pkg::CODE_EXT)
              || (rp.code == bvs_pkg::CODE_EXT);
    cost    = 8'(STEP_MV);
    if (SKIP_CODE != bvs_pkg::NO_SKIP) begin
      if ((up && (rp.code + 5'h01 == SKIP_CODE)) || (!up && (rp.code == SKIP_CODE))) begin
        cost = 8'(2 * STEP_MV);
      end
    end
    sum = acc + {4'h0, rp.rate};
  end

  // mV accumulated per microsecond, one code step per step voltage
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rp.code <= bvs_pkg::sat_code(INIT_CODE);
      acc     <= 8'h00;
    end else if (!rp.go || (rp.code == rp.target)) begin
      acc <= 8'h00; // hold
    end else if (instant) begin
      rp.code <= rp.target;
      acc     <= 8'h00;
    end else if (rp.us_tick) begin
      if (sum >= cost) begin
        rp.code <= up ? rp.code + 5'h01 : rp.code - 5'h01;
        acc     <= sum - cost;
      end else begin
        acc <= sum;
      end
    end
  end
endmodule

/* sim/bvs_host.sv */
`timescale 1ns/100ps
// host side of the register strobe port
module bvs_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  // idle bus at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // one write strobe; released lines show the inverse, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // one read strobe; answer taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    v = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
endmodule

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       wr;
  logic       rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic [4:0] sec_i     = 5'h07;
  logic [4:0] one;
  logic [4:0] two;
  int         miscompares = 0;
  int         checks      = 0;
  logic [31:0] seed       = 32'hc663e454;
  int         m [int];

  // 250 MHz clock
  always #2 ref_clk_i = ~ref_clk_i;

  bvs_host host_u (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

  bvs_top dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_two_second_target_i(sec_i),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_one_active_code_o(one),
    .reg_two_active_code_o(two));

  ////////////////////////////////////////////////////////////////////////////////
  // reference model and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected read value of the register model
  function automatic int exp_rd(input int a);
    case (a)
      32'h20:  exp_rd = m[a] & 32'h33;
      32'h23, 32'h24, 32'h29: exp_rd = m[a] & 32'h1f;
      32'h25:  exp_rd = 32'h20 | (m[a] & 32'h0f);
      default: exp_rd = 0;
    endcase
  endfunction

  function automatic int sat(input int c);
    sat = (c > 25) ? 25 : c;
  endfunction

  task automatic cmp_rd(input logic [7:0] got, input logic v, input int exp);
    checks++;
    if (v !== 1'b1 || got !== exp[7:0]) begin
      miscompares++;
      $display("Error at %0t: read %h valid %b, wanted %h", $time, got, v, exp[7:0]);
    end
  endtask

  task automatic cmp_code(input logic [4:0] got, input int exp);
    checks++;
    if (got !== exp[4:0]) begin
      miscompares++;
      $display("Error at %0t: code %h, wanted %h", $time, got, exp[4:0]);
    end
  endtask

  task automatic w(input int a, input int d);
    host_u.wr(a[7:0], d[7:0]);
    m[a] = d;
  endtask

  task automatic chk(input int a);
    logic [7:0] d;
    logic       v;
    host_u.rd(a[7:0], d, v);
    cmp_rd(d, v, exp_rd(a));
  endtask

  // bounded wait for an active code, then compare
  task automatic wait_code(input int r, input int exp, input int lim);
    for (int i = 0; i < lim; i++) begin
      if ((r ? two : one) === exp[4:0])
        break;
      @(posedge ref_clk_i);
    end
    cmp_code(r ? two : one, exp);
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the longest ramp sequence
  initial begin
    #120000;
    miscompares++;
    end_of_test;
  end

  // main sequence
  initial begin
    m[32'h20] = 0;
    m[32'h23] = 9;
    m[32'h24] = 9;
    m[32'h25] = 8;
    m[32'h29] = 25;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    cmp_code(one, 9);
    cmp_code(two, 25);
    foreach (m[a]) chk(a);
    chk(32'h21);
    $display("test reset done");
    // reserved bits and unmapped offset
    w(32'h23, 32'hff);
    w(32'h24, 32'hff);
    w(32'h29, 32'hff);
    w(32'h25, 32'hff);
    w(32'h20, 32'hcc);
    w(32'h21, 32'hff);
    m.delete(32'h21);
    foreach (m[a]) chk(a);
    chk(32'h21);
    $display("test access done");
    // instant ramp to random targets, then second target
    w(32'h25, 32'h00);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      w(32'h23, seed[7:0]);
      w(32'h20, 32'h01);
      wait_code(0, sat(seed[4:0]), 4);
    end
    w(32'h20, 32'h03);
    wait_code(0, 25, 4);
    $display("test instant done");
    // rate above ten acts as ten: 5 us per 50 mV step
    w(32'h25, 32'h0f);
    w(32'h24, 32'h18);
    repeat (950) @(posedge ref_clk_i);
    cmp_code(one, 25);
    wait_code(0, 24, 400);
    w(32'h24, 32'h10);
    w(32'h20, 32'h02);
    repeat (2000) @(posedge ref_clk_i);
    cmp_code(one, 24);
    $display("test slow done");
    // regulator two: external code, second target, skipped point
    w(32'h29, 32'h00);
    w(32'h20, 32'h10);
    wait_code(1, 0, 4);
    seed = lfsr(seed);
    sec_i <= seed[4:0];
    w(32'h20, 32'h30);
    wait_code(1, sat(seed[4:0]), 4);
    // pass through external control so the jump to the second target is instant
    sec_i <= 5'h0d;
    w(32'h20, 32'h10);
    wait_code(1, 0, 4);
    w(32'h20, 32'h30);
    wait_code(1, 13, 4);
    @(posedge ref_clk_i);
    sec_i <= 5'h0e;
    repeat (5900) @(posedge ref_clk_i);
    cmp_code(two, 13);
    wait_code(1, 14, 400);
    $display("test second done");
    end_of_test;
  end
endmodule
